// *** pei_pkg.sv ***
// Constants shared by the event interrupt logic: offsets, fields, reset values.
package pei_pkg;
	// ***************************************************************
	// Bus geometry
	// ***************************************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int NUM_EVT = 6;

	// ***************************************************************
	// Register offsets
	// ***************************************************************
	localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 5'h11;
	localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 5'h12;
	localparam logic [ADDR_W-1:0] ADDR_SYS_STAT = 5'h18;
	localparam logic [ADDR_W-1:0] ADDR_SYS_MASK = 5'h19;

	// ***************************************************************
	// Control register fields
	// ***************************************************************
	localparam int CTRL_FD_COL = 4;
	localparam int CTRL_LEVEL_SEL = 3;
	localparam int CTRL_TEST = 2;
	localparam int CTRL_INT_EN = 1;
	localparam int CTRL_OUT_EN = 0;
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0108;
	localparam logic [DATA_W-1:0] CTRL_WR_MASK = 16'hFB1F;

	// ***************************************************************
	// Event status register layout
	// ***************************************************************
	localparam int STAT_FLAG_LSB = 8;
	localparam int STAT_EN_LSB = 0;
	localparam logic [NUM_EVT-1:0] EVT_EN_RESET = 6'h00;
	// Event index inside the six-bit groups
	localparam int EVT_LINK = 5;
	localparam int EVT_SPEED = 4;
	localparam int EVT_DUPLEX = 3;
	localparam int EVT_AN_DONE = 2;
	localparam int EVT_FC_HALF = 1;
	localparam int EVT_RE_HALF = 0;

	// ***************************************************************
	// Counter half-full thresholds
	// ***************************************************************
	localparam int FC_CNT_W = 8;
	localparam int RE_CNT_W = 16;
	localparam logic [FC_CNT_W-1:0] FC_HALF_LIMIT = 8'h7F;
	localparam logic [RE_CNT_W-1:0] RE_HALF_LIMIT = 16'h7FFF;
endpackage

// *** pei_pin_if.sv ***
// Interface between the control core and the shared pin driver.
`timescale 1ns/1ns
interface pei_pin_if;
	logic irq_active;
	logic level_select;
	logic output_enable;
	logic pin_level;
	logic pin_drive;
	logic pin_en;
	logic powerdown;

	modport core (
		output irq_active,
		output level_select,
		output output_enable,
		output pin_level,
		input pin_drive,
		input pin_en,
		input powerdown
	);
	modport drv (
		input irq_active,
		input level_select,
		input output_enable,
		input pin_level,
		output pin_drive,
		output pin_en,
		output powerdown
	);
endinterface

// *** pei_sticky_flag.sv ***
// One pending-event flag: set by an event, cleared by its owner.
`timescale 1ns/1ns
module pei_sticky_flag (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic set_in,
	input wire logic clr_in,
	output logic flag_out
);
	// Set beats clear so an event landing on the clearing cycle survives
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= 1'b0;
		end else if (set_in) begin
			flag_out <= 1'b1;
		end else if (clr_in) begin
			flag_out <= 1'b0;
		end
	end
endmodule

// *** pei_pin_drive.sv ***
// Shared interrupt / power-down pin: polarity, enable and input sense.
`timescale 1ns/1ns
module pei_pin_drive (
	input wire logic clk_in,
	input wire logic rst_n_in,
	pei_pin_if.drv pin
);
	// Drive level: asserted state is the inverse of the idle level
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin.pin_drive <= 1'b1;
			pin.pin_en <= 1'b0;
		end else begin
			pin.pin_en <= pin.output_enable;
			if (pin.output_enable) begin
				pin.pin_drive <= pin.irq_active ^ pin.level_select;
			end else begin
				pin.pin_drive <= pin.level_select;
			end
		end
	end

	// Power-down sense, active low on the pin, only while output enable is off
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin.powerdown <= 1'b0;
		end else begin
			pin.powerdown <= !pin.output_enable && !pin.pin_level;
		end
	end
endmodule

// *** pei_top.sv ***
// Event interrupt logic: status flags, enables, control bits and pin.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module pei_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [pei_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [pei_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [pei_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic link_status_in,
	input wire logic speed_status_in,
	input wire logic duplex_status_in,
	input wire logic an_complete_in,
	input wire logic [pei_pkg::FC_CNT_W-1:0] false_carrier_counter_in,
	input wire logic [pei_pkg::RE_CNT_W-1:0] rx_symbol_error_counter_in,
	input wire logic collision_raw_in,
	output logic collision_out,
	input wire logic irq_or_powerdown_pin_in,
	output logic irq_or_powerdown_pin_out,
	output logic irq_or_powerdown_pin_oe_out,
	output logic powerdown_out,
	output logic sys_irq_out
);
	import pei_pkg::*;

	// ***************************************************************
	// Reset release
	// ***************************************************************

	logic rst_meta_q;
	logic rst_sync_q;

	// Assert at once, release only after two clean edges; a release that
	// lands near an edge then cannot split the core across two cycles
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ***************************************************************
	// Register decode
	// ***************************************************************

	logic wr_ctrl;
	logic wr_stat;
	logic wr_sys_stat;
	logic wr_sys_mask;
	logic rd_stat;

	// One-hot strobes per register
	assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_PHY_CTRL);
	assign wr_stat = reg_wr_in && (reg_addr_in == ADDR_EVT_STAT);
	assign wr_sys_stat = reg_wr_in && (reg_addr_in == ADDR_SYS_STAT);
	assign wr_sys_mask = reg_wr_in && (reg_addr_in == ADDR_SYS_MASK);
	assign rd_stat = reg_rd_in && (reg_addr_in == ADDR_EVT_STAT);

	// ***************************************************************
	// Control register
	// ***************************************************************

	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] ctrl_d;
	logic fd_col_en;
	logic level_sel;
	logic test_irq;
	logic int_en;
	logic out_en;

	// Only the writable fields take the new value; reserved stay zero,
	// so a read never shows a reserved bit that software once wrote
	assign ctrl_d = (ctrl_q & ~CTRL_WR_MASK) | (reg_wdata_in & CTRL_WR_MASK);

	// Control fields, level select comes out of reset set
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_d;
		end
	end

	// Field aliases so the logic below reads by meaning
	assign fd_col_en = ctrl_q[CTRL_FD_COL];
	assign level_sel = ctrl_q[CTRL_LEVEL_SEL];
	assign test_irq = ctrl_q[CTRL_TEST];
	assign int_en = ctrl_q[CTRL_INT_EN];
	assign out_en = ctrl_q[CTRL_OUT_EN];

	// ***************************************************************
	// Collision qualifier
	// ***************************************************************

	// Full duplex hides collision unless software asks for it
	// Registered so a duplex change cannot glitch the qualified output
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			collision_out <= 1'b0;
		end else begin
			collision_out <= collision_raw_in && (fd_col_en || !duplex_status_in);
		end
	end

	// ***************************************************************
	// Event detection
	// ***************************************************************

	logic primed_q;
	logic link_prev_q;
	logic speed_prev_q;
	logic duplex_prev_q;
	logic an_prev_q;
	logic fc_over_q;
	logic re_over_q;
	logic fc_over;
	logic re_over;
	logic [NUM_EVT-1:0] evt_pulse;

	// Half-full means strictly above the midpoint
	assign fc_over = false_carrier_counter_in > FC_HALF_LIMIT;
	assign re_over = rx_symbol_error_counter_in > RE_HALF_LIMIT;

	// Previous samples; the first sample after reset only primes them,
	// so a link already up at reset does not look like a change
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			primed_q <= 1'b0;
			link_prev_q <= 1'b0;
			speed_prev_q <= 1'b0;
			duplex_prev_q <= 1'b0;
			an_prev_q <= 1'b0;
			fc_over_q <= 1'b0;
			re_over_q <= 1'b0;
		end else begin
			primed_q <= 1'b1;
			link_prev_q <= link_status_in;
			speed_prev_q <= speed_status_in;
			duplex_prev_q <= duplex_status_in;
			an_prev_q <= an_complete_in;
			fc_over_q <= fc_over;
			re_over_q <= re_over;
		end
	end

	// Changes for status levels, rising edges for completion and limits;
	// every detector waits for the priming edge, so a level that is
	// already high when reset lifts is not taken for a fresh event
	assign evt_pulse[EVT_LINK] = primed_q && (link_status_in != link_prev_q);
	assign evt_pulse[EVT_SPEED] = primed_q && (speed_status_in != speed_prev_q);
	assign evt_pulse[EVT_DUPLEX] = primed_q && (duplex_status_in != duplex_prev_q);
	assign evt_pulse[EVT_AN_DONE] = primed_q && an_complete_in && !an_prev_q;
	assign evt_pulse[EVT_FC_HALF] = primed_q && fc_over && !fc_over_q;
	assign evt_pulse[EVT_RE_HALF] = primed_q && re_over && !re_over_q;

	// ***************************************************************
	// Event flags and enables
	// ***************************************************************

	logic [NUM_EVT-1:0] evt_flag;
	logic [NUM_EVT-1:0] evt_en_q;
	logic [NUM_EVT-1:0] sys_flag;
	logic [NUM_EVT-1:0] sys_mask_q;
	logic [NUM_EVT-1:0] sys_clr;

	// Write-one-to-clear strobes for the system copy; zeros leave a flag
	assign sys_clr = wr_sys_stat ? reg_wdata_in[NUM_EVT-1:0] : '0;

	// Flags set whatever the enables say; a status read clears them,
	// but an event on the clearing edge wins and shows at the next read
	for (genvar i = 0; i < NUM_EVT; i++) begin : g_flag
		pei_sticky_flag u_evt_flag (
			.clk_in(clk_in),
			.rst_n_in(rst_sync_q),
			.set_in(evt_pulse[i]),
			.clr_in(rd_stat),
			.flag_out(evt_flag[i])
		);
		// System copy of the same events, write one to clear
		pei_sticky_flag u_sys_flag (
			.clk_in(clk_in),
			.rst_n_in(rst_sync_q),
			.set_in(evt_pulse[i]),
			.clr_in(sys_clr[i]),
			.flag_out(sys_flag[i])
		);
	end

	// Per-event enables; writes to the flag half are ignored
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			evt_en_q <= EVT_EN_RESET;
		end else if (wr_stat) begin
			evt_en_q <= reg_wdata_in[STAT_EN_LSB +: NUM_EVT];
		end
	end

	// System interrupt mask, one bit per event
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sys_mask_q <= EVT_EN_RESET;
		end else if (wr_sys_mask) begin
			sys_mask_q <= reg_wdata_in[NUM_EVT-1:0];
		end
	end

	// ***************************************************************
	// Pending terms
	// ***************************************************************

	logic [NUM_EVT-1:0] evt_pending;
	logic [NUM_EVT-1:0] sys_pending;

	// Flags that software has chosen to hear about on the pin
	assign evt_pending = evt_flag & evt_en_q;
	// Flags that reach the system interrupt line
	assign sys_pending = sys_flag & sys_mask_q;

	// System interrupt level, held while any unmasked flag is pending
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sys_irq_out <= 1'b0;
		end else begin
			sys_irq_out <= |sys_pending;
		end
	end

	// ***************************************************************
	// Interrupt condition and pin
	// ***************************************************************

	logic irq_event;
	logic irq_active;

	// Events need their own enable plus the global gate
	assign irq_event = int_en && |evt_pending;
	// Test bit bypasses every event term as long as it is held; the term
	// runs even with the pin disabled, so it shows once the enable is set
	assign irq_active = test_irq || irq_event;

	pei_pin_if pin_bus ();

	// Core side of the pin carrier
	assign pin_bus.irq_active = irq_active;
	assign pin_bus.level_select = level_sel;
	assign pin_bus.output_enable = out_en;
	assign pin_bus.pin_level = irq_or_powerdown_pin_in;

	// Pin driver registers level, enable and power-down sense. Limitation:
	// for one cycle after output enable drops the pin may still carry our
	// own low level, which the sense takes as a power-down request
	pei_pin_drive u_pin (
		.clk_in(clk_in),
		.rst_n_in(rst_sync_q),
		.pin(pin_bus.drv)
	);

	// Pin outputs come straight from the driver's flip-flops
	assign irq_or_powerdown_pin_out = pin_bus.pin_drive;
	assign irq_or_powerdown_pin_oe_out = pin_bus.pin_en;
	assign powerdown_out = pin_bus.powerdown;

	// ***************************************************************
	// Read data
	// ***************************************************************

	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] sys_stat_word;
	logic [DATA_W-1:0] sys_mask_word;

	// Status word: flags above enables, reserved fields tied low
	always_comb begin
		stat_word = '0;
		stat_word[STAT_FLAG_LSB +: NUM_EVT] = evt_flag;
		stat_word[STAT_EN_LSB +: NUM_EVT] = evt_en_q;
	end

	// System words keep the event order in their low bits
	always_comb begin
		sys_stat_word = '0;
		sys_mask_word = '0;
		sys_stat_word[NUM_EVT-1:0] = sys_flag;
		sys_mask_word[NUM_EVT-1:0] = sys_mask_q;
	end

	// Unmapped offsets read zero
	always_comb begin
		rdata_d = '0;
		unique case (reg_addr_in)
			ADDR_PHY_CTRL: begin
				rdata_d = ctrl_q;
			end
			ADDR_EVT_STAT: begin
				rdata_d = stat_word;
			end
			ADDR_SYS_STAT: begin
				rdata_d = sys_stat_word;
			end
			ADDR_SYS_MASK: begin
				rdata_d = sys_mask_word;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	// and is zero otherwise, so a stray sample never shows stale status
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end else begin
			reg_rdata_out <= '0;
		end
	end
endmodule

// *** pei_top_asserts.sv ***
// Port-level checker for the event interrupt logic, with its bind.
`timescale 1ns/1ns
module pei_top_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [pei_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [pei_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [pei_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic duplex_status_in,
	input wire logic collision_raw_in,
	input wire logic collision_out,
	input wire logic irq_or_powerdown_pin_in,
	input wire logic irq_or_powerdown_pin_out,
	input wire logic irq_or_powerdown_pin_oe_out,
	input wire logic powerdown_out
);
	import pei_pkg::*;
	logic [DATA_W-1:0] ctrl_q;
	logic [2:0] live_q;
	logic live;
	logic col_exp;
	logic rd_stat;
	// ***************
	// Helper logic
	// ***************
	// Shadow of the control register, rebuilt from bus writes
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= CTRL_RESET;
		end else if (reg_wr_in && reg_addr_in == ADDR_PHY_CTRL) begin
			ctrl_q <= reg_wdata_in & CTRL_WR_MASK;
		end
	end
	// Skip edges while the reset synchroniser still holds the core
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			live_q <= 3'h0;
		end else if (live_q != 3'h4) begin
			live_q <= live_q + 3'h1;
		end
	end
	// Expected terms, sampled by $past below
	assign live = (live_q == 3'h4);
	assign col_exp = collision_raw_in & (ctrl_q[CTRL_FD_COL] | !duplex_status_in);
	assign rd_stat = reg_rd_in && (reg_addr_in == ADDR_EVT_STAT);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ***************
	// Properties
	// ***************
	a_col_gate: assert property (live |-> collision_out == $past(col_exp))
		else $error("collision output wrong");
	a_oe_select: assert property (live |-> irq_or_powerdown_pin_oe_out == $past(ctrl_q[0]))
		else $error("pin enable does not follow control");
	a_idle_level: assert property (live && !irq_or_powerdown_pin_oe_out
		|-> irq_or_powerdown_pin_out == $past(ctrl_q[3])) else $error("pin idle level wrong");
	a_test_force: assert property (live && $past(ctrl_q[2]) && irq_or_powerdown_pin_oe_out
		|-> irq_or_powerdown_pin_out != $past(ctrl_q[3])) else $error("test bit not forcing");
	a_gate_off: assert property (live && irq_or_powerdown_pin_oe_out && $past(ctrl_q[2:1]) == 2'h0
		|-> irq_or_powerdown_pin_out == $past(ctrl_q[3])) else $error("ungated interrupt");
	a_pwdn_sense: assert property ((live && !ctrl_q[0] && !irq_or_powerdown_pin_in)[*2]
		|=> powerdown_out) else $error("power-down not sensed");
	a_rdata_idle: assert property (live && !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data outside read slot");
	a_status_rsvd: assert property (live && $past(rd_stat)
		|-> reg_rdata_out[15:14] == 2'h0 && reg_rdata_out[7:6] == 2'h0) else $error("reserved bits set");
endmodule
bind pei_top pei_top_asserts u_chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .duplex_status_in, .collision_raw_in, .collision_out,
	.irq_or_powerdown_pin_in, .irq_or_powerdown_pin_out, .irq_or_powerdown_pin_oe_out,
	.powerdown_out);

// *** pei_host_model.sv ***
// Management host side of the shared pin: senses it or pulls it for power-down.
`timescale 1ns/1ns
module pei_host_model (
	input wire logic pin_out_in,
	input wire logic pin_oe_in,
	input wire logic pwdn_req_in,
	output logic pin_level_out
);
	// Pull-up holds the pin high unless the host pulls it low while undriven
	assign pin_level_out = pin_oe_in ? pin_out_in : !pwdn_req_in;
endmodule

// *** pei_top_test.sv ***
// Self-checking bench for the event interrupt logic.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", nm, ex, got); end end
module pei_top_test;
	import pei_pkg::*;
	logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [ADDR_W-1:0] reg_addr_in = 5'h00;
	logic [DATA_W-1:0] reg_wdata_in = 16'h0000, reg_rdata_out;
	logic link_status_in = 1'b0, speed_status_in = 1'b0, duplex_status_in = 1'b0;
	logic an_complete_in = 1'b0, collision_raw_in = 1'b1, pwdn_req = 1'b0;
	logic [FC_CNT_W-1:0] false_carrier_counter_in = 8'h00;
	logic [RE_CNT_W-1:0] rx_symbol_error_counter_in = 16'h0000;
	logic collision_out, irq_or_powerdown_pin_out, irq_or_powerdown_pin_oe_out;
	logic powerdown_out, sys_irq_out;
	wire logic irq_or_powerdown_pin_in;
	logic [31:0] seed = 32'h6;
	int n_errors = 0, total_checks = 0, cycles = 0, m_ctrl, m_en, m_flag, m_sys, m_mask;
	logic [15:0] cfg [4] = '{16'h000B, 16'h0009, 16'h0003, 16'h0017};
	logic [15:0] tcfg [6] = '{16'h000D, 16'h0005, 16'h0004, 16'h000C, 16'h0001, 16'h0010};
	logic [4:0] addrs [5] = '{5'h11, 5'h12, 5'h18, 5'h19, 5'h05};
	// ***************
	// Design and host
	// ***************
	pei_top DUT (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .link_status_in, .speed_status_in, .duplex_status_in, .an_complete_in,
		.false_carrier_counter_in, .rx_symbol_error_counter_in, .collision_raw_in, .collision_out,
		.irq_or_powerdown_pin_in, .irq_or_powerdown_pin_out, .irq_or_powerdown_pin_oe_out,
		.powerdown_out, .sys_irq_out);
	pei_host_model HOST (.pin_out_in(irq_or_powerdown_pin_out),
		.pin_oe_in(irq_or_powerdown_pin_oe_out), .pwdn_req_in(pwdn_req),
		.pin_level_out(irq_or_powerdown_pin_in));
	// ***************
	// Helpers
	// ***************
	// Clock and hang guard
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic conclude();
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Bus write, then the model follows the register's access rules
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		case (a)
			ADDR_PHY_CTRL: m_ctrl = d & CTRL_WR_MASK;
			ADDR_EVT_STAT: m_en = d[5:0];
			ADDR_SYS_STAT: m_sys = m_sys & ~d[5:0];
			ADDR_SYS_MASK: m_mask = d[5:0];
			default: ;
		endcase
	endtask
	// Bus read; event status reads empty the model's event flags
	task automatic rd(input logic [4:0] a);
		logic [15:0] ex;
		ex = 16'h0000;
		case (a)
			ADDR_PHY_CTRL: ex = 16'(m_ctrl);
			ADDR_EVT_STAT: ex = 16'((m_flag << 8) | m_en);
			ADDR_SYS_STAT: ex = 16'(m_sys);
			ADDR_SYS_MASK: ex = 16'(m_mask);
			default: ;
		endcase
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		`CHK("rdata", ex, reg_rdata_out)
		if (a == ADDR_EVT_STAT) begin
			m_flag = 0;
		end
	endtask
	// One event; counters step from just below half to just above
	task automatic ev(input int i);
		@(posedge clk_in);
		case (i)
			5: link_status_in <= ~link_status_in;
			4: speed_status_in <= ~speed_status_in;
			3: duplex_status_in <= ~duplex_status_in;
			2: an_complete_in <= 1'b1;
			1: false_carrier_counter_in <= 8'h80;
			default: rx_symbol_error_counter_in <= 16'h8000;
		endcase
		@(posedge clk_in);
		an_complete_in <= 1'b0;
		false_carrier_counter_in <= 8'h7F;
		rx_symbol_error_counter_in <= 16'h7FFF;
		m_flag = m_flag | (1 << i);
		m_sys = m_sys | (1 << i);
	endtask
	// Pin, power-down, collision and system interrupt against the model
	task automatic chk();
		logic irq, pin;
		irq = m_ctrl[2] | (m_ctrl[1] & ((m_flag & m_en) != 0));
		pin = m_ctrl[0] ? irq ^ m_ctrl[3] : m_ctrl[3];
		@(posedge clk_in);
		collision_raw_in <= 1'(rnd());
		repeat (4) @(posedge clk_in);
		#1;
		`CHK("pin", pin, irq_or_powerdown_pin_out)
		`CHK("pin_oe", 1'(m_ctrl[0]), irq_or_powerdown_pin_oe_out)
		`CHK("powerdown", !m_ctrl[0] & pwdn_req, powerdown_out)
		`CHK("sys_irq", (m_sys & m_mask) != 0, sys_irq_out)
		`CHK("collision", collision_raw_in & (m_ctrl[4] | !duplex_status_in), collision_out)
	endtask
	// ***************
	// Main sequence
	// ***************
	initial begin
		m_ctrl = CTRL_RESET;
		m_en = 0;
		m_flag = 0;
		m_sys = 0;
		m_mask = 0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk();
		foreach (addrs[k]) rd(addrs[k]);
		@(posedge clk_in);
		false_carrier_counter_in <= 8'h7F;
		rx_symbol_error_counter_in <= 16'h7FFF;
		rd(ADDR_EVT_STAT);
		// Random writes, some to unmapped or reserved places
		for (int k = 0; k < 6; k++) begin
			wr(5'(rnd()), 16'(rnd()));
			wr(ADDR_EVT_STAT, 16'(rnd()));
			rd(5'(rnd()));
			rd(ADDR_PHY_CTRL);
			rd(ADDR_EVT_STAT);
			chk();
		end
		// Each event under gate on, gate off, wrong enable, test
		for (int i = 0; i < NUM_EVT; i++) begin
			for (int c = 0; c < 4; c++) begin
				wr(ADDR_PHY_CTRL, cfg[c]);
				wr(ADDR_EVT_STAT, c == 2 ? 16'(~(1 << i) & 32'h3F) : 16'h003F);
				wr(ADDR_SYS_MASK, 16'(rnd() & 32'h3F));
				ev(i);
				chk();
				rd(ADDR_EVT_STAT);
				rd(ADDR_EVT_STAT);
				chk();
				rd(ADDR_SYS_STAT);
				wr(ADDR_SYS_STAT, 16'(rnd()));
				chk();
				rd(ADDR_SYS_STAT);
			end
		end
		// Test bit, polarity and power-down sense
		foreach (tcfg[k]) begin
			pwdn_req <= (k == 2) || 1'(rnd());
			wr(ADDR_PHY_CTRL, tcfg[k]);
			chk();
		end
		conclude();
	end
endmodule
